// ==== rtl/spsd_core.sv ====
// Serial programming port, dividers and phase/frequency detector
// Behaviour
// - Frame is swallow7, main10, reference11, MSB first
// - Sample data on serial clock fall, enable high
// - Data high is one, low is zero
// - Under 28 edges: load swallow, main only
// - 28 edges: reference latch loads too
// - Enable low ignores data and clock
// - Enable fall latches words, resyncs detector
// - Reference divides oscillator by twice value
// - Modulus low until swallow done, then high
// - Swallow 0-127, main 3-1023, main>=swallow
// - Division equals main times modulus plus swallow
// - Coarse output up, down, or released locked
// - Lock output driven low only when locked
// - Counter outputs change on counting clock rise
// - Swallow, main clocked from prescaled input
// - Reprogram zeroes counters then reloads
`timescale 1ns/1ps
`include "spsd_map.svh"
module spsd_core
  import spsd_pkg::*;
#(
  parameter int LOCK_WIN = 2
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic serial_data,
  input  wire logic serial_clock,
  input  wire logic serial_enable,
  input  wire logic osc_input_clock,
  input  wire logic prescaled_input_clock,
  output logic      modulus_select_output,
  output logic      coarse_phase_output,
  output logic      coarse_phase_oe,
  output logic      lock_indicator,
  output logic      lock_indicator_oe,
  output logic      divided_vco_pulse,
  output logic      divided_reference_pulse
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Every input but clk and reset_n is asynchronous; two flops before any logic reads it
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic [4:0] prev_q;
  always_ff @(posedge clk) begin
    sync1_q <= {serial_data, serial_clock, serial_enable, osc_input_clock, prescaled_input_clock};
    sync2_q <= sync1_q;
    prev_q  <= sync2_q;
  end
  wire logic dat_s   = sync2_q[4];
  wire logic sck_s   = sync2_q[3];
  wire logic en_s    = sync2_q[2];
  wire logic sck_fall = prev_q[3] & ~sck_s & en_s;
  wire logic en_rise  = ~prev_q[2] & en_s;
  wire logic en_fall  = prev_q[2] & ~en_s;
  wire logic osc_rise = ~prev_q[1] & sync2_q[1];
  wire logic fin_rise = ~prev_q[0] & sync2_q[0];

  // ----------------------------------------------------------------
  // Serial shift register and edge counter
  // ----------------------------------------------------------------
  logic [`SPSD_FRAME_BITS-1:0] shift_q;
  logic [4:0]                  edges_q;
  wire logic edges_full = (edges_q == 5'(`SPSD_FRAME_BITS));
  // Single register: after 17 bits, swallow sits at the top of the low 17 bits, main below it
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      shift_q <= '0;
      edges_q <= '0;
    end else begin
      if (sck_fall) begin
        shift_q <= {shift_q[`SPSD_FRAME_BITS-2:0], dat_s};
      end
      if (en_rise) begin
        edges_q <= '0;
      end else if (sck_fall && !edges_full) begin
        edges_q <= edges_q + 5'h01;
      end
    end
  end
  // Full frame: bits at fixed positions; short frame: swallow/main in low 17 bits
  wire logic [6:0]  sh_sw_full   = shift_q[`SPSD_SW_LSB +: 7];
  wire logic [9:0]  sh_main_full = shift_q[`SPSD_MAIN_LSB +: 10];
  wire logic [6:0]  sh_sw_short  = shift_q[`SPSD_SHORT_BITS-1 -: 7];
  wire logic [9:0]  sh_main_short = shift_q[9:0];
  wire logic [10:0] sh_ref       = shift_q[`SPSD_REF_LSB +: 11];

  // ----------------------------------------------------------------
  // Counter latches
  // ----------------------------------------------------------------
  spsd_word_s latch_q;
  logic       reload_q;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      latch_q  <= '{swallow: `SPSD_SW_RST, main: `SPSD_MAIN_RST, reference: `SPSD_REF_RST};
      reload_q <= 1'b0;
    end else begin
      reload_q <= en_fall;
      if (en_fall) begin
        if (edges_full) begin
          latch_q.swallow   <= sh_sw_full;
          latch_q.main      <= sh_main_full;
          latch_q.reference <= sh_ref;
        end else begin
          latch_q.swallow <= sh_sw_short;
          latch_q.main    <= sh_main_short;
        end
      end
    end
  end
  // Values below the documented minimum are clamped; hardware cannot divide by less
  wire logic [10:0] ref_val = (latch_q.reference < `SPSD_MIN_DIV_INIT) ? `SPSD_MIN_DIV_INIT
                                                                       : latch_q.reference;
  wire logic [9:0]  main_val = (latch_q.main < `SPSD_MAIN_MIN) ? `SPSD_MAIN_MIN : latch_q.main;

  // ----------------------------------------------------------------
  // Reference divider: ref_val oscillator rises per half period
  // ----------------------------------------------------------------
  logic [10:0] ref_cnt_q;
  logic        ref_half_q;
  logic        fr_q;
  wire  logic  ref_tc = (ref_cnt_q >= ref_val - 11'h001);
  always_ff @(posedge clk) begin
    if (!reset_n || en_fall) begin
      ref_cnt_q  <= '0;
      ref_half_q <= 1'b0;
      fr_q       <= 1'b0;
    end else begin
      fr_q <= 1'b0;
      if (osc_rise) begin
        if (ref_tc) begin
          ref_cnt_q  <= '0;
          ref_half_q <= ~ref_half_q;
          fr_q       <= ref_half_q;
        end else begin
          ref_cnt_q <= ref_cnt_q + 11'h001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Swallow and main counters, modulus select
  // ----------------------------------------------------------------
  logic [6:0] sw_cnt_q;
  logic [9:0] main_cnt_q;
  logic       mod_q;
  logic       fv_q;
  wire  logic main_tc = (main_cnt_q == main_val - 10'h001);
  wire  logic sw_tc   = (sw_cnt_q == latch_q.swallow);
  // Per cycle: swallow prescaler cycles at N+1 (low), rest at N: total M*N+A
  always_ff @(posedge clk) begin
    if (!reset_n || en_fall) begin
      sw_cnt_q   <= '0;
      main_cnt_q <= '0;
      mod_q      <= 1'b0;
      fv_q       <= 1'b0;
    end else begin
      fv_q <= 1'b0;
      if (fin_rise) begin
        if (main_tc) begin
          main_cnt_q <= '0;
          sw_cnt_q   <= '0;
          mod_q      <= (latch_q.swallow == 7'h00);
          fv_q       <= 1'b1;
        end else begin
          main_cnt_q <= main_cnt_q + 10'h001;
          if (!sw_tc) begin
            sw_cnt_q <= sw_cnt_q + 7'h01;
          end
          mod_q <= mod_q | (sw_cnt_q + 7'h01 == latch_q.swallow);
        end
      end
    end
  end
  // Low through the swallow phase, high until the main count wraps
  assign modulus_select_output   = mod_q;
  assign divided_vco_pulse       = fv_q;
  assign divided_reference_pulse = fr_q;

  // ----------------------------------------------------------------
  // Phase/frequency detector and lock window
  // ----------------------------------------------------------------
  logic        up_q;
  logic        dn_q;
  logic [7:0]  err_q;
  logic        lock_q;
  spsd_pd_e    pd_q;
  always_ff @(posedge clk) begin
    if (!reset_n || reload_q) begin
      up_q   <= 1'b0;
      dn_q   <= 1'b0;
      err_q  <= '0;
      lock_q <= 1'b0;
      pd_q   <= SPSD_PD_IDLE;
    end else begin
      if ((fv_q | up_q) & (fr_q | dn_q)) begin
        up_q  <= 1'b0;
        dn_q  <= 1'b0;
        lock_q <= (err_q + 8'h01 <= 8'(LOCK_WIN));
        err_q <= '0;
      end else begin
        up_q <= up_q | fv_q;
        dn_q <= dn_q | fr_q;
        if (up_q | dn_q | fv_q | fr_q) begin
          err_q <= (err_q == 8'hff) ? err_q : err_q + 8'h01;
        end
      end
      case ({up_q & ~lock_q, dn_q & ~lock_q})
        2'b10:   pd_q <= SPSD_PD_UP;
        2'b01:   pd_q <= SPSD_PD_DOWN;
        default: pd_q <= SPSD_PD_IDLE;
      endcase
    end
  end
  assign coarse_phase_output = (pd_q == SPSD_PD_UP);
  assign coarse_phase_oe     = (pd_q != SPSD_PD_IDLE);
  assign lock_indicator      = 1'b0;
  assign lock_indicator_oe   = lock_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence frame_end_s;
    en_fall ##1 reload_q;
  endsequence
  edge_sat_a: assert property (@(posedge clk) disable iff (!reset_n) edges_full && sck_fall |=> edges_full) else $error("edge counter left saturation");
  edge_rst_a: assert property (@(posedge clk) disable iff (!reset_n) en_rise |=> edges_q == 5'h00) else $error("edge counter not restarted");
  ref_keep_a: assert property (@(posedge clk) disable iff (!reset_n) en_fall && !edges_full |=> $stable(latch_q.reference)) else $error("reference latch changed on short frame");
  ref_load_a: assert property (@(posedge clk) disable iff (!reset_n) en_fall && edges_full |=> latch_q.reference == $past(sh_ref)) else $error("reference latch not loaded");
  idle_shift_a: assert property (@(posedge clk) disable iff (!reset_n) !en_s && !$past(en_s) |=> $stable(shift_q)) else $error("shift while enable low");
  // Detector clears one cycle after the counters, so its check waits a cycle
  reload_zero_a: assert property (@(posedge clk) disable iff (!reset_n) frame_end_s |-> main_cnt_q == 10'h000 && sw_cnt_q == 7'h00 ##1 !up_q && !dn_q) else $error("counters not zeroed on reprogram");
  fv_tc_a: assert property (@(posedge clk) disable iff (!reset_n) fin_rise && main_tc && !en_fall |=> fv_q && main_cnt_q == 10'h000) else $error("divided pulse missing at terminal count");
  mod_hold_a: assert property (@(posedge clk) disable iff (!reset_n) !fin_rise && !en_fall |=> $stable(modulus_select_output)) else $error("modulus select moved without input rise");
  lock_pd_a: assert property (@(posedge clk) disable iff (!reset_n) lock_q |=> !coarse_phase_oe) else $error("coarse output driven while locked");

  // ----------------------------------------------------------------
  // Count cycle and latch checks
  // ----------------------------------------------------------------
  // Terminal count of the main counter, not cut by a reprogram
  sequence count_wrap_s;
    fin_rise && main_tc && !en_fall;
  endsequence
  // Last swallow step of a running count cycle
  sequence swallow_done_s;
    fin_rise && !main_tc && !en_fall && (sw_cnt_q + 7'h01 == latch_q.swallow);
  endsequence
  mod_start_a: assert property (@(posedge clk) disable iff (!reset_n) count_wrap_s ##0 latch_q.swallow != 7'h00 |=> !modulus_select_output) else $error("modulus select not low at cycle start");
  mod_rise_a: assert property (@(posedge clk) disable iff (!reset_n) swallow_done_s |=> modulus_select_output) else $error("modulus select not high after swallow");
  fv_pulse_a: assert property (@(posedge clk) disable iff (!reset_n) fv_q |=> !fv_q) else $error("divided pulse longer than one cycle");
  fr_pulse_a: assert property (@(posedge clk) disable iff (!reset_n) fr_q |=> !fr_q) else $error("reference pulse longer than one cycle");
  shift_in_a: assert property (@(posedge clk) disable iff (!reset_n) sck_fall |=> shift_q[0] == $past(dat_s)) else $error("serial bit not shifted in");
  sw_short_a: assert property (@(posedge clk) disable iff (!reset_n) en_fall && !edges_full |=> latch_q.swallow == $past(sh_sw_short)) else $error("swallow latch wrong on short frame");
  main_full_a: assert property (@(posedge clk) disable iff (!reset_n) en_fall && edges_full |=> latch_q.main == $past(sh_main_full)) else $error("main latch wrong on full frame");
  ref_zero_a: assert property (@(posedge clk) disable iff (!reset_n) en_fall |=> ref_cnt_q == 11'h000 && !ref_half_q) else $error("reference divider not zeroed");
  pd_idle_a: assert property (@(posedge clk) disable iff (!reset_n) !up_q && !dn_q |=> !coarse_phase_oe) else $error("coarse output driven with no pending edge");
endmodule

// ==== rtl/spsd_map.svh ====
// Constant map for the serially programmed synthesiser dividers
`ifndef SPSD_MAP_SVH
`define SPSD_MAP_SVH
`define SPSD_FRAME_BITS    28
`define SPSD_SHORT_BITS    17
`define SPSD_SW_LSB        21
`define SPSD_MAIN_LSB      11
`define SPSD_REF_LSB       0
`define SPSD_SW_RST        7'h00
`define SPSD_MAIN_RST      10'h003
`define SPSD_REF_RST       11'h003
`define SPSD_MIN_DIV_INIT  11'h003
`define SPSD_MAIN_MIN      10'h003
`endif

// ==== rtl/spsd_pkg.sv ====
// Types for the serially programmed synthesiser dividers
package spsd_pkg;
  typedef struct packed {
    logic [6:0]  swallow;
    logic [9:0]  main;
    logic [10:0] reference;
  } spsd_word_s;
  typedef enum logic [1:0] {
    SPSD_PD_IDLE,
    SPSD_PD_UP,
    SPSD_PD_DOWN
  } spsd_pd_e;
endpackage

// ==== tb/spsd_host.sv ====
// Host model that shifts programming frames into the synthesiser
`timescale 1ns/1ps
module spsd_host (
  output logic serial_data,
  output logic serial_clock,
  output logic serial_enable
);
  // Clock parks high between frames so enable may move at any time
  initial begin
    serial_data   = 1'b0;
    serial_clock  = 1'b1;
    serial_enable = 1'b0;
  end

  // Frame of n bits, MSB first; data set while clock high, taken on fall
  task automatic send(input logic [27:0] w, input int n);
    serial_enable = 1'b1;
    #32;
    for (int i = 0; i < n; i++) begin
      serial_data = w[27-i];
      #32 serial_clock = 1'b0;
      #32 serial_clock = 1'b1;
    end
    #32 serial_enable = 1'b0;
    // No pull-up: a released data line must not look held
    serial_data = ~serial_data;
  endtask

  // Clock and data chatter while enable stays low
  task automatic noise(input int n);
    for (int i = 0; i < n; i++) begin
      #32 serial_clock = ~serial_clock;
      serial_data = 1'(($urandom));
    end
    serial_clock = 1'b1;
  endtask
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the synthesiser dividers
`timescale 1ns/1ps
module tb;
  import spsd_pkg::*;
  logic clk;
  logic reset_n;
  logic osc_clk;
  logic pre_clk;
  logic sd, sc, se, mso, cpo, cpoe, lki, lkoe, dvp, drp;
  int   errors, samples_checked, a_m, m_m, r_m, a_r, m_r, r_r, lo_r, seed_v;

  spsd_host u_host (.serial_data(sd), .serial_clock(sc), .serial_enable(se));
  spsd_core u_dut (
    .clk                    (clk),
    .reset_n                (reset_n),
    .serial_data            (sd),
    .serial_clock           (sc),
    .serial_enable          (se),
    .osc_input_clock        (osc_clk),
    .prescaled_input_clock  (pre_clk),
    .modulus_select_output  (mso),
    .coarse_phase_output    (cpo),
    .coarse_phase_oe        (cpoe),
    .lock_indicator         (lki),
    .lock_indicator_oe      (lkoe),
    .divided_vco_pulse      (dvp),
    .divided_reference_pulse(drp)
  );

  // Oscillator 40 ns (10 clk), prescaler 48 ns (12 clk); edges avoid clk rises
  always #2 clk = ~clk;
  always #20 osc_clk = ~osc_clk;
  always #24 pre_clk = ~pre_clk;

  task automatic check(input string what, input int exp, input int got);
    samples_checked++;
    if (exp != got) begin
      errors++;
      $display("BAD %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // Cycles between 2nd and 3rd pulse; skips the restart after reload
  task automatic span(input bit sel, output int n, output int low);
    int k;
    k   = 0;
    n   = 0;
    low = 0;
    for (int t = 0; t < 6000 && k < 3; t++) begin
      @(posedge clk);
      #1;
      if ((sel ? drp : dvp) === 1'b1) k++;
      if (k == 2) begin
        n++;
        if (mso === 1'b0) low++;
      end
    end
    if (k < 3) check("pulse_count", 3, k);
  endtask

  // Program one frame, then compare periods with the model
  task automatic run(input int a, input int m, input int r, input int nb);
    int per, low;
    @(negedge clk);
    u_host.send({a[6:0], m[9:0], r[10:0]}, nb);
    a_m = a;
    m_m = m;
    if (nb == 28) r_m = r;
    repeat (8) @(posedge clk);
    span(1'b0, per, low);
    check("vco_period", m_m * 12, per);
    check("swallow_low", a_m * 12, low);
    span(1'b1, per, low);
    check("ref_period", r_m * 20, per);
    check("lock_drive_level", 1, int'(lki === 1'b0));
    $display("test a=%0d m=%0d r=%0d bits=%0d done", a, m, r, nb);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    errors = 0;
    samples_checked = 0;
    clk = 1'b0;
    osc_clk = 1'b0;
    pre_clk = 1'b0;
    reset_n = 1'b0;
    r_m = 3;
    seed_v = $urandom(32'h495064fd);
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    run(5, 20, 3, 28);
    u_host.noise(6);
    run(9, 30, 5, 17);
    for (int i = 0; i < 4; i++) begin
      a_r = $urandom_range(20);
      lo_r = (a_r < 3) ? 3 : a_r;
      m_r = $urandom_range(60, lo_r);
      r_r = $urandom_range(40, 3);
      run(a_r, m_r, r_r, 28);
    end
    final_report;
  end

  // Hang guard, well past the expected run length
  initial begin
    #200000;
    errors++;
    final_report;
  end
endmodule
